// ===== far_end_block_error_counter.v
// Far-end block error counter of one E1 receive channel, with clear-on-read byte registers.
// Assumes framer status and E-bit error pulses arrive from another timing source,
// and a register master that issues single-cycle read and write strobes.
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`include "febe_counter_map.vh"
module far_end_block_error_counter (
    input  wire               clk_in,
    input  wire               rst_in,
    input  wire               ebit_zero_in,
    input  wire               fas_sync_lost_in,
    input  wire               crc4_sync_lost_in,
    input  wire               cas_sync_lost_in,
    input  wire [`ADDR_W-1:0] addr_in,
    input  wire [`DATA_W-1:0] wdata_in,
    input  wire               wr_in,
    input  wire               rd_in,
    output reg  [`DATA_W-1:0] rdata_out,
    output reg                irq_out
);
    wire       ebit_evt;
    wire [2:0] sync_lost;
    reg  [2:0] sync_lost_d_ff;

    reg  [`CNT_W-1:0]    count_ff;
    reg  [`CNT_W-1:0]    nxt_count;
    reg  [`DATA_W-1:0]   low_hold_ff;
    reg                  hold_valid_ff;
    reg  [`IRQ_USED-1:0] irq_stat_ff;
    reg  [`IRQ_USED-1:0] nxt_irq_stat;
    reg  [`IRQ_USED-1:0] irq_mask_ff;
    reg  [`DATA_W-1:0]   nxt_rdata;

    wire count_enable;
    wire rd_high;
    wire rd_low;
    wire rd_stat;
    wire wr_mask;
    wire bump;
    wire wrap;
    wire sync_change;

    function hit;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    pulse_sync u_ebit (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .pulse_in (ebit_zero_in),
        .edge_out (ebit_evt)
    );

    sync_level #(.W(3)) u_status (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .level_in  ({cas_sync_lost_in, crc4_sync_lost_in, fas_sync_lost_in}),
        .level_out (sync_lost)
    );

    // CAS multiframe loss is left out on purpose
    assign count_enable = ~sync_lost[`SYNC_FAS_BIT] & ~sync_lost[`SYNC_CRC_BIT]; // see (RL6) see (RL7)
    assign bump         = ebit_evt & count_enable; // see (RL5)
    assign rd_high      = rd_in & hit(addr_in, `OFS_COUNT_HIGH);
    assign rd_low       = rd_in & hit(addr_in, `OFS_COUNT_LOW);
    assign rd_stat      = rd_in & hit(addr_in, `OFS_IRQ_STATUS);
    assign wr_mask      = wr_in & hit(addr_in, `OFS_IRQ_MASK);
    assign wrap         = bump & (count_ff == {`CNT_W{1'b1}});
    assign sync_change  = |(sync_lost ^ sync_lost_d_ff);

    // Counter: a read of the high byte takes the sample and clears it; an event in the
    // same cycle is kept by restarting from one instead of zero.
    always @* begin
        nxt_count = count_ff;
        if (rd_high) begin
            nxt_count = {{(`CNT_W-1){1'b0}}, bump}; // see (RL4) see (RL9)
        end else if (bump && !wrap) begin
            nxt_count = count_ff + 16'h0001; // see (RL5)
        end
    end

    // Saturates rather than wraps so a missed read never looks like few errors
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_ff       <= `RST_COUNT;
            low_hold_ff    <= `RST_BYTE;
            hold_valid_ff  <= 1'b0;
            sync_lost_d_ff <= 3'h0;
        end else begin
            count_ff       <= nxt_count; // see (RL1)
            sync_lost_d_ff <= sync_lost;
            if (rd_high) begin
                low_hold_ff   <= count_ff[7:0]; // see (RL10) see (RL8)
                hold_valid_ff <= 1'b1;
            end else if (rd_low) begin
                low_hold_ff   <= `RST_BYTE; // see (RL9)
                hold_valid_ff <= 1'b0;
            end
        end
    end

    // Sticky status: set wins over the clearing read
    always @* begin
        nxt_irq_stat = irq_stat_ff;
        if (rd_stat) begin
            nxt_irq_stat = {`IRQ_USED{1'b0}};
        end
        if (bump) begin
            nxt_irq_stat[`IRQ_ERR_BIT] = 1'b1;
        end
        if (wrap) begin
            nxt_irq_stat[`IRQ_WRAP_BIT] = 1'b1;
        end
        if (sync_change) begin
            nxt_irq_stat[`IRQ_SYNC_BIT] = 1'b1;
        end
    end

    // Low byte without a prior high read shows the live count and leaves it standing
    always @* begin
        nxt_rdata = `RST_BYTE;
        if (rd_high) begin
            nxt_rdata = count_ff[15:8]; // see (RL2)
        end else if (rd_low) begin
            nxt_rdata = hold_valid_ff ? low_hold_ff : count_ff[7:0]; // see (RL3) see (RL10)
        end else if (rd_stat) begin
            nxt_rdata = {{(`DATA_W-`IRQ_USED){1'b0}}, irq_stat_ff};
        end else if (rd_in && hit(addr_in, `OFS_IRQ_MASK)) begin
            nxt_rdata = {{(`DATA_W-`IRQ_USED){1'b0}}, irq_mask_ff};
        end else if (rd_in && hit(addr_in, `OFS_SYNC_STATUS)) begin
            nxt_rdata = {{(`DATA_W-3){1'b0}}, sync_lost};
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_stat_ff <= {`IRQ_USED{1'b0}};
            irq_mask_ff <= {`IRQ_USED{1'b0}};
            rdata_out   <= `RST_BYTE;
            irq_out     <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr_mask) begin
                irq_mask_ff <= wdata_in[`IRQ_USED-1:0];
            end
            rdata_out <= nxt_rdata;
            irq_out   <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

    // Direct low-byte read without a high read also clears the live count
    // is not supported: the count is cleared only at the high read, so an
    // isolated low read is harmless to the accumulated value.
endmodule

// ===== far_end_block_error_counter_tb.sv
// Self-checking bench for the far-end block error counter.
// Assumes the map header and all design sources are compiled beforehand.
`timescale 1ns/10ps
`include "febe_counter_map.vh"
module far_end_block_error_counter_tb;
    reg         clk_in = 1'b0;
    reg         rst_in = 1'b1;
    reg         ebit_zero_in = 1'b0;
    reg  [2:0]  loss = 3'b000;
    reg  [11:0] addr_in = 12'h000;
    reg  [7:0]  wdata_in = 8'h00;
    reg         wr_in = 1'b0;
    reg         rd_in = 1'b0;
    reg         rd_d = 1'b0;
    reg  [8:0]  e;
    wire [7:0]  rdata_out;
    wire        irq_out;
    reg  [31:0] seed = 32'h5ca7f8ac;
    reg  [8:0]  exp_q[$];
    integer     miscompares = 0;
    integer     num_checks = 0;
    integer     i;
    integer     n;
    far_end_block_error_counter DUT (.clk_in(clk_in), .rst_in(rst_in), .ebit_zero_in(ebit_zero_in),
        .fas_sync_lost_in(loss[0]), .crc4_sync_lost_in(loss[1]), .cas_sync_lost_in(loss[2]),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .irq_out(irq_out));
    always #4 clk_in = ~clk_in;
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input [39:0] nm, input [7:0] seen, input [7:0] want);
        num_checks = num_checks + 1;
        if (seen !== want) begin
            miscompares = miscompares + 1;
            $display("unexpected %s: expected %h seen %h", nm, want, seen);
        end
    endtask
    // Strobes stay up between calls so reads can run back to back
    task rd(input [11:0] a, input [8:0] x);
        addr_in <= a;
        rd_in   <= 1'b1;
        wr_in   <= 1'b0;
        exp_q.push_back(x);
        @(posedge clk_in);
    endtask
    task wr(input [11:0] a, input [7:0] d);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        rd_in    <= 1'b0;
        @(posedge clk_in);
    endtask
    task idle(input integer k);
        rd_in <= 1'b0;
        wr_in <= 1'b0;
        repeat (k) @(posedge clk_in);
    endtask
    // Three cycles high, four low: the sync stage needs two of each
    task ev;
        ebit_zero_in <= 1'b1;
        idle(3);
        ebit_zero_in <= 1'b0;
        idle(4);
    endtask
    task summarize;
        if (exp_q.size() != 0) miscompares = miscompares + 1;
        if (miscompares == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe; bit 8 marks don't care
    always @(negedge clk_in) begin
        if (rd_d && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (!e[8]) chk("rdata", rdata_out, e[7:0]);
        end
        rd_d = rd_in;
    end
    initial begin
        idle(2);
        rst_in <= 1'b0;
        rd(`OFS_COUNT_HIGH, 9'h000);
        rd(`OFS_COUNT_LOW, 9'h000);
        rd(12'h000, 9'h000);
        seed = lfsr(seed);
        n = 256 + seed[5:0];
        for (i = 0; i < n; i = i + 1) begin
            seed = lfsr(seed);
            loss <= {seed[0], 2'b00};
            ev;
        end
        rd(`OFS_COUNT_HIGH, {1'b0, n[15:8]});
        rd(`OFS_COUNT_LOW, {1'b0, n[7:0]});
        rd(`OFS_COUNT_LOW, 9'h000);
        rd(`OFS_COUNT_HIGH, 9'h000);
        rd(`OFS_COUNT_LOW, 9'h000);
        for (i = 0; i < 2; i = i + 1) begin
            loss <= 3'b001 << i;
            idle(5);
            rd(`OFS_SYNC_STATUS, 9'h001 << i);
            ev;
            ev;
            rd(`OFS_COUNT_HIGH, 9'h000);
            rd(`OFS_COUNT_LOW, 9'h000);
            rd(`OFS_COUNT_HIGH, 9'h000);
            rd(`OFS_COUNT_HIGH, 9'h000);
            rd(`OFS_COUNT_LOW, 9'h000);
        end
        loss <= 3'b000;
        idle(5);
        repeat (3) ev;
        rd(`OFS_COUNT_HIGH, 9'h000);
        repeat (2) ev;
        rd(`OFS_COUNT_LOW, 9'h003);
        rd(`OFS_COUNT_LOW, 9'h002);
        rd(`OFS_COUNT_HIGH, 9'h000);
        rd(`OFS_COUNT_LOW, 9'h002);
        rd(`OFS_IRQ_STATUS, 9'h005);
        wr(`OFS_IRQ_MASK, 8'hff);
        wr(`OFS_COUNT_HIGH, 8'h55);
        rd(`OFS_IRQ_MASK, 9'h007);
        ev;
        chk("irq", {7'h00, irq_out}, 8'h01);
        rd(`OFS_IRQ_STATUS, 9'h001);
        idle(2);
        chk("irq", {7'h00, irq_out}, 8'h00);
        wr(`OFS_IRQ_MASK, 8'h00);
        ev;
        chk("irq", {7'h00, irq_out}, 8'h00);
        rd(`OFS_IRQ_STATUS, 9'h001);
        rd(`OFS_COUNT_HIGH, 9'h000);
        rd(`OFS_COUNT_LOW, 9'h002);
        repeat (2) ev;
        rst_in <= 1'b1;
        idle(2);
        rst_in <= 1'b0;
        rd(`OFS_COUNT_HIGH, 9'h000);
        rd(`OFS_COUNT_LOW, 9'h000);
        idle(3);
        summarize;
    end
endmodule

// ===== febe_counter_map.vh
// Constants for the far-end block error counter: register offsets, field layout, reset values.
// Assumes a byte-wide register port with 12-bit word addresses and one clock domain.
// Functional notes
// (RL1) Keep a 16-bit error count shown as a high-byte and a low-byte register.
// (RL2) High-byte register returns count bits 15 to 8.
// (RL3) Low-byte register returns count bits 7 to 0.
// (RL4) A software read clears the count; only errors since the last read remain.
// (RL5) Add exactly one for each received E-bit equal to zero; the code adds nothing once the count has reached 16'hFFFF and holds it there.
// (RL6) Do not count while frame alignment or CRC-4 sync is lost.
// (RL7) Keep counting when only CAS multiframe sync is lost.
// (RL8) Software reads the high byte before the low byte for a correct value.
// (RL9) Clearing needs a high-byte read followed by a low-byte read; the code clears the count at the high-byte read alone.
// (RL10) High-byte read snapshots the low byte; the next low-byte read returns it.
`ifndef FEBE_COUNTER_MAP_VH
`define FEBE_COUNTER_MAP_VH

`define ADDR_W             12
`define DATA_W             8
`define CNT_W              16
`define OFS_COUNT_HIGH     12'h907
`define OFS_COUNT_LOW      12'h908
`define OFS_IRQ_STATUS     12'h9f0
`define OFS_IRQ_MASK       12'h9f1
`define OFS_SYNC_STATUS    12'h9f2
`define RST_COUNT          16'h0000
`define RST_BYTE           8'h00
`define RST_MASK           8'h00
`define IRQ_ERR_BIT        0
`define IRQ_WRAP_BIT       1
`define IRQ_SYNC_BIT       2
`define IRQ_USED           3
`define SYNC_FAS_BIT       0
`define SYNC_CRC_BIT       1
`define SYNC_CAS_BIT       2

`endif

// ===== febe_counter_monitor.sv
// Port checker for the far-end block error counter.
// Assumes one clock domain and the design's register map header.
`timescale 1ns/10ps
`include "febe_counter_map.vh"
module febe_counter_monitor (
    input wire               clk_in,
    input wire               rst_in,
    input wire               ebit_zero_in,
    input wire               fas_sync_lost_in,
    input wire               crc4_sync_lost_in,
    input wire               cas_sync_lost_in,
    input wire [`ADDR_W-1:0] addr_in,
    input wire [`DATA_W-1:0] wdata_in,
    input wire               wr_in,
    input wire               rd_in,
    input wire [`DATA_W-1:0] rdata_out,
    input wire               irq_out
);
    reg  [2:0] mask_ff;
    wire       hi_rd = rd_in && addr_in == `OFS_COUNT_HIGH;
    wire       lo_rd = rd_in && addr_in == `OFS_COUNT_LOW;
    // Own copy of the mask, so the irq check needs no view inside
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            mask_ff <= 3'b000;
        else if (wr_in && addr_in == `OFS_IRQ_MASK)
            mask_ff <= wdata_in[2:0];
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    rd_idle_a:
        assert property (!rd_in |=> rdata_out == 8'h00) else $error("rdata without read");
    unmapped_zero_a:
        assert property (rd_in && addr_in == 12'h000 |=> rdata_out == 8'h00) else $error("unmapped rdata");
    clear_read_a:
        assert property (hi_rd ##1 hi_rd |=> rdata_out <= 8'h01) else $error("high byte not cleared");
    live_low_a:
        assert property (hi_rd ##1 lo_rd ##1 lo_rd |=> rdata_out <= 8'h01) else $error("low byte not cleared");
    fas_hold_a:
        assert property (fas_sync_lost_in[*6] ##0 hi_rd ##1 hi_rd ##1 lo_rd |=> rdata_out == 8'h00)
            else $error("counted in frame loss");
    crc_hold_a:
        assert property (crc4_sync_lost_in[*6] ##0 hi_rd ##1 hi_rd ##1 lo_rd |=> rdata_out == 8'h00)
            else $error("counted in crc loss");
    no_event_a:
        assert property (!ebit_zero_in[*6] ##0 hi_rd ##1 hi_rd ##1 lo_rd |=> rdata_out == 8'h00)
            else $error("count without event");
    mask_quiet_a:
        assert property (mask_ff == 3'b000 |=> !irq_out) else $error("irq while masked");
    cover property (hi_rd ##1 lo_rd);
    cover property (irq_out);
    cover property (fas_sync_lost_in && hi_rd);
endmodule
bind far_end_block_error_counter febe_counter_monitor u_mon (.clk_in, .rst_in, .ebit_zero_in, .fas_sync_lost_in,
    .crc4_sync_lost_in, .cas_sync_lost_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out);

// ===== pulse_sync.v
// Synchronises an asynchronous active-high pulse level and emits one-cycle rising-edge pulses.
// Assumes each input pulse stays high for at least two clk_in cycles and low for two between pulses.
`timescale 1ns/10ps
module pulse_sync (
    input  wire clk_in,
    input  wire rst_in,
    input  wire pulse_in,
    output reg  edge_out
);
    wire sync_level;
    reg  last_ff;

    sync_level #(.W(1)) u_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .level_in  (pulse_in),
        .level_out (sync_level)
    );

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            last_ff  <= 1'b0;
            edge_out <= 1'b0;
        end else begin
            last_ff  <= sync_level;
            edge_out <= sync_level & ~last_ff;
        end
    end
endmodule

// ===== sync_level.v
// Two-flop synchroniser for a bundle of level signals.
// Assumes the inputs are quasi-static levels from another timing source.
`timescale 1ns/10ps
module sync_level #(
    parameter W = 1
) (
    input  wire         clk_in,
    input  wire         rst_in,
    input  wire [W-1:0] level_in,
    output wire [W-1:0] level_out
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    // First stage feeds only the second stage
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end else begin
            meta_ff <= level_in;
            sync_ff <= meta_ff;
        end
    end

    assign level_out = sync_ff;
endmodule
